// >>> urw_defines.svh
// register offsets, field positions and sample timing constants for the receiver
`ifndef URW_DEFINES_SVH
`define URW_DEFINES_SVH
// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define URW_OFF_CTL1      8'h00
`define URW_OFF_CTL2      8'h04
`define URW_OFF_CTL3      8'h08
`define URW_OFF_STAT1     8'h0c
`define URW_OFF_DATA      8'h10
`define URW_OFF_BRK       8'h14
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define URW_C1_IDLE_TYPE  0
`define URW_C1_WAKE_SEL   1
`define URW_C1_LEN9       2
`define URW_C1_PAR_EN     3
`define URW_C1_PAR_ODD    4
`define URW_C1_DIV_LO     8
`define URW_C1_DIV_HI     15
`define URW_C2_RXIE       0
`define URW_C2_IDLE_IRQ_EN       1
`define URW_C2_STBY       2
`define URW_S_PE          0
`define URW_S_FE          1
`define URW_S_NF          2
`define URW_S_OR          3
`define URW_S_IDLE        4
`define URW_S_FULL        5
// ----------------------------------------------------------------------------
// sample clock positions and counts
// ----------------------------------------------------------------------------
`define URW_RT_FIRST      5'h01
`define URW_RT_EDGE_NEXT  5'h02
`define URW_RT_S3         5'h03
`define URW_RT_LATE_EDGE  5'h04
`define URW_RT_S5         5'h05
`define URW_RT_S7         5'h07
`define URW_RT_S8         5'h08
`define URW_RT_S9         5'h09
`define URW_RT_S10        5'h0a
`define URW_RT_LAST       5'h10
`define URW_LAST_BIT8     4'h7
`define URW_LAST_BIT9     4'h8
`define URW_IDLE_T8       8'ha0
`define URW_IDLE_T9       8'hb0
`define URW_RESP_OKAY     2'h0
`define URW_RESP_SLVERR   2'h2
`endif

// >>> urw_pkg.sv
// types shared by the receiver: states, register select, bus carriers, state record
package urw_pkg;
	typedef enum logic [1:0] {URW_RX_IDLE = 2'b00, URW_RX_START = 2'b01,
		URW_RX_DATA = 2'b10, URW_RX_STOP = 2'b11} urw_rx_state_t;
	typedef enum logic [2:0] {URW_R_CTL1 = 3'b000, URW_R_CTL2 = 3'b001, URW_R_CTL3 = 3'b010,
		URW_R_STAT = 3'b011, URW_R_DATA = 3'b100, URW_R_BRK = 3'b101,
		URW_R_NONE = 3'b111} urw_reg_sel_t;
	typedef struct packed {
		logic        awvalid; logic [31:0] awaddr;
		logic        wvalid;  logic [31:0] wdata; logic [3:0] wstrb;
		logic        bready;
		logic        arvalid; logic [31:0] araddr;
		logic        rready;
	} urw_axi_in_t;
	typedef struct packed {
		logic        awready; logic wready;
		logic        bvalid;  logic [1:0] bresp;
		logic        arready;
		logic        rvalid;  logic [31:0] rdata; logic [1:0] rresp;
	} urw_axi_out_t;
	typedef struct packed {
		logic rx_s1; logic rx_s2; logic [2:0] hist;
		logic [7:0] div_cnt; logic [4:0] rt; urw_rx_state_t fsm;
		logic [3:0] bit_idx; logic [1:0] samp; logic [8:0] shreg;
		logic last_bit; logic nf_acc; logic [7:0] ones; logic idle_armed;
		logic [15:0] ctl1; logic [2:0] ctl2; logic [3:0] ctl3; logic bce;
		logic [5:0] stat; logic [8:0] data; logic arm;
		logic aw_hold; logic [31:0] awaddr; logic w_hold; logic [31:0] wdata; logic [3:0] wstrb;
		logic awrdy; logic wrdy; logic bvalid; logic [1:0] bresp;
		logic arrdy; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
		logic rx_irq; logic err_irq;
	} urw_state_t;
endpackage

// >>> urw_rx_top.sv
// serial receiver with standby wakeup, error flags and an axi4-lite register slave
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "urw_defines.svh"

// Behaviour
// RULE_01: zero stop sample sets framing error flag
// RULE_02: framing error rises with receive-full flag
// RULE_03: break character also sets framing error
// RULE_04: stop sampled thrice; one miss noise only
// RULE_05: realign sample clock on falling edges
// RULE_06: stop sample at tenth oversample cycle
// RULE_07: standby bit mutes receiver interrupt requests
// RULE_08: address mark wakes and sets receive-full
// RULE_09: software re-arms standby on address mismatch
// RULE_10: idle character wakes, sets no flags
// RULE_11: idle type picks where ones counting starts
// RULE_12: clearing wake select may wake immediately
// RULE_13: receive-full set on transfer, gated by enable
// RULE_14: idle flag after 10 or 11 ones
// RULE_15: overrun keeps old data, drops new
// RULE_16: noise flag on any noisy bit
// RULE_17: framing enable gates error interrupt
// RULE_18: parity mismatch sets parity error flag
// RULE_19: wait mode keeps running, interrupts wake
// RULE_20: registers unreachable during wait mode
// RULE_21: stop mode halts, registers kept, frame lost
// RULE_22: locked debug break leaves flags untouched
// RULE_23: flags cleared in open break stay cleared
// RULE_24: idle type one counts after stop bit
// RULE_25: wake select one means address mark
// RULE_26: error request ORs enabled error flags
// RULE_27: standby forces receive and idle requests off
module urw_rx_top (
	input  wire logic                  sys_clk_i,      // 100 mhz system clock
	input  wire logic                  reset_n_i,      // async reset, active low
	input  wire logic                  clk_en_i,       // freezes all state when low
	input  wire logic                  rx_pin_i,       // serial receive line
	input  wire logic                  wait_mode_i,    // processor in wait mode
	input  wire logic                  stop_mode_i,    // processor in stop mode
	input  wire logic                  debug_break_i,  // debug break state
	input  wire urw_pkg::urw_axi_in_t  axi_i,          // axi4-lite requests
	output urw_pkg::urw_axi_out_t      axi_o,          // axi4-lite answers
	output logic                       rx_irq_o,       // receiver interrupt request
	output logic                       err_irq_o       // error interrupt request
);
	import urw_pkg::*;

	// ------------------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------------------
	function automatic urw_reg_sel_t dec_addr(input logic [31:0] a);
		urw_reg_sel_t s;
		s = URW_R_NONE;
		if (a[31:8] == 24'h000000) begin
			case (a[7:0])
				`URW_OFF_CTL1:  s = URW_R_CTL1;
				`URW_OFF_CTL2:  s = URW_R_CTL2;
				`URW_OFF_CTL3:  s = URW_R_CTL3;
				`URW_OFF_STAT1: s = URW_R_STAT;
				`URW_OFF_DATA:  s = URW_R_DATA;
				`URW_OFF_BRK:   s = URW_R_BRK;
				default:        s = URW_R_NONE;
			endcase
		end
		return s;
	endfunction

	function automatic logic [1:0] ones_of(input logic [2:0] s);
		return {1'b0, s[0]} + {1'b0, s[1]} + {1'b0, s[2]};
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------------------
	// state and helper signals
	// ------------------------------------------------------------------------
	urw_state_t   st;
	urw_state_t   st_next;
	logic         tick, line, stby, wake_sel, len9, cnt_en, lock;
	logic         done_ev, ld_ev, ld_ok, ovr_ev, resync_ev, edge_ev, idle_hit;
	logic         rd_hs, wr_go, clr_flags, bit_v, par_bad, fe_v, nf_v;
	logic [2:0]   smp3;
	logic [1:0]   ones3;
	logic [7:0]   idle_thr;
	logic [3:0]   last_bit_idx;
	logic [8:0]   chr;
	logic [31:0]  wtmp;
	urw_reg_sel_t rsel, wsel;

	// outputs straight from the state record
	assign axi_o.awready = st.awrdy;
	assign axi_o.wready  = st.wrdy;
	assign axi_o.bvalid  = st.bvalid;
	assign axi_o.bresp   = st.bresp;
	assign axi_o.arready = st.arrdy;
	assign axi_o.rvalid  = st.rvalid;
	assign axi_o.rdata   = st.rdata;
	assign axi_o.rresp   = st.rresp;
	assign rx_irq_o      = st.rx_irq;
	assign err_irq_o     = st.err_irq;
	assign ld_ok         = ld_ev & clk_en_i;

	// ------------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------------
	always_comb begin
		st_next      = st;
		line         = st.rx_s2;
		tick         = (st.div_cnt == 8'h00);
		stby         = st.ctl2[`URW_C2_STBY];
		wake_sel     = st.ctl1[`URW_C1_WAKE_SEL];
		len9         = st.ctl1[`URW_C1_LEN9];
		idle_thr     = len9 ? `URW_IDLE_T9 : `URW_IDLE_T8;
		last_bit_idx = len9 ? `URW_LAST_BIT9 : `URW_LAST_BIT8;
		smp3         = {st.samp, line};
		ones3        = ones_of(smp3);
		bit_v        = ones3[1];
		nf_v         = (ones3 != 2'h0) && (ones3 != 2'h3);
		fe_v         = !ones3[1];
		chr          = len9 ? st.shreg : {st.shreg[8], st.shreg[8:1]};
		par_bad      = st.ctl1[`URW_C1_PAR_EN] & ((^st.shreg) != st.ctl1[`URW_C1_PAR_ODD]);
		edge_ev      = st.hist[0] && !line && st.last_bit;
		cnt_en       = st.ctl1[`URW_C1_IDLE_TYPE] ? (st.fsm == URW_RX_IDLE)
			: (st.fsm != URW_RX_START); // RULE_11 RULE_24
		lock         = debug_break_i && !st.bce;
		done_ev      = 1'b0;
		ld_ev        = 1'b0;
		ovr_ev       = 1'b0;
		resync_ev    = 1'b0;
		idle_hit     = 1'b0;
		clr_flags    = 1'b0;
		rd_hs        = axi_i.arvalid && st.arrdy;
		wr_go        = st.aw_hold && st.w_hold && !st.bvalid;
		rsel         = dec_addr(axi_i.araddr);
		wsel         = dec_addr(st.awaddr);
		wtmp         = 32'h00000000;

		// pin synchroniser; first stage feeds only the second
		st_next.rx_s1 = rx_pin_i;
		st_next.rx_s2 = st.rx_s1;

		// register reads and the two-step flag clear (status read, then data read)
		if (rd_hs) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = 32'h00000000;
			st_next.rresp  = `URW_RESP_OKAY;
			if (wait_mode_i || stop_mode_i || rsel == URW_R_NONE) begin
				st_next.rresp = `URW_RESP_SLVERR; // RULE_20
			end else begin
				case (rsel)
					URW_R_CTL1: st_next.rdata = {16'h0000, st.ctl1};
					URW_R_CTL2: st_next.rdata = {29'h00000000, st.ctl2};
					URW_R_CTL3: st_next.rdata = {28'h0000000, st.ctl3};
					URW_R_STAT: st_next.rdata = {26'h0000000, st.stat};
					URW_R_DATA: st_next.rdata = {23'h000000, st.data};
					URW_R_BRK:  st_next.rdata = {31'h00000000, st.bce};
					default:    st_next.rdata = 32'h00000000;
				endcase
				// a locked break keeps both the arm and the flags as they are
				if (!lock) begin // RULE_22 RULE_23
					if (rsel == URW_R_STAT && st.stat != 6'h00) begin
						st_next.arm = 1'b1;
					end
					if (rsel == URW_R_DATA && st.arm) begin
						clr_flags   = 1'b1;
						st_next.arm = 1'b0;
					end
				end
			end
		end else if (st.rvalid && axi_i.rready) begin
			st_next.rvalid = 1'b0;
		end
		if (clr_flags) begin
			st_next.stat = 6'h00;
		end

		// receiver; stop mode halts it and drops any character in flight
		if (stop_mode_i) begin
			st_next.fsm = URW_RX_IDLE; // RULE_21
		end else begin // RULE_19
			st_next.div_cnt = tick ? st.ctl1[`URW_C1_DIV_HI:`URW_C1_DIV_LO]
				: st.div_cnt - 8'h01;
			if (tick) begin
				st_next.hist = {st.hist[1:0], line};
				st_next.rt   = (st.rt == `URW_RT_LAST) ? `URW_RT_FIRST : st.rt + 5'h01;
				case (st.fsm)
					URW_RX_IDLE: begin
						// start search: a low after three highs
						if (st.hist == 3'h7 && !line) begin
							st_next.fsm      = URW_RX_START;
							st_next.rt       = `URW_RT_EDGE_NEXT;
							st_next.nf_acc   = 1'b0;
							st_next.shreg    = 9'h000;
							st_next.samp     = 2'h0;
							st_next.last_bit = 1'b0;
						end
					end
					URW_RX_START: begin
						if (st.rt == `URW_RT_S3 || st.rt == `URW_RT_S5) begin
							st_next.samp = {st.samp[0], line};
						end
						if (st.rt == `URW_RT_S7) begin
							if (ones3[1]) begin
								st_next.fsm = URW_RX_IDLE;
							end else begin
								st_next.nf_acc = (smp3 != 3'h0); // RULE_16
							end
						end
						// late highs inside a verified start only mark noise
						if ((st.rt == `URW_RT_S8 || st.rt == `URW_RT_S9 || st.rt == `URW_RT_S10)
							&& line) begin
							st_next.nf_acc = 1'b1; // RULE_16
						end
						if (st.rt == `URW_RT_LAST) begin
							st_next.fsm     = URW_RX_DATA;
							st_next.bit_idx = 4'h0;
						end
					end
					URW_RX_DATA: begin
						if (st.rt == `URW_RT_S8 || st.rt == `URW_RT_S9) begin
							st_next.samp = {st.samp[0], line};
						end
						if (st.rt == `URW_RT_S10) begin
							st_next.shreg    = {bit_v, st.shreg[8:1]};
							st_next.last_bit = bit_v;
							st_next.nf_acc   = st.nf_acc | nf_v; // RULE_16
						end
						// a one-to-zero edge realigns the 16x count
						if (edge_ev && st.rt > `URW_RT_S10) begin
							resync_ev = 1'b1; // RULE_05
						end else if (edge_ev && st.rt <= `URW_RT_LATE_EDGE) begin
							st_next.rt = `URW_RT_EDGE_NEXT; // RULE_05
						end
						if (st.rt == `URW_RT_LAST || resync_ev) begin
							st_next.bit_idx = st.bit_idx + 4'h1;
							if (resync_ev) begin
								st_next.rt = `URW_RT_EDGE_NEXT;
							end
							if (st.bit_idx == last_bit_idx) begin
								st_next.fsm = URW_RX_STOP;
							end
						end
					end
					URW_RX_STOP: begin
						if (st.rt == `URW_RT_S8 || st.rt == `URW_RT_S9) begin
							st_next.samp = {st.samp[0], line};
						end
						// stop decided on the tenth oversample cycle
						if (st.rt == `URW_RT_S10) begin // RULE_06
							done_ev            = 1'b1;
							st_next.fsm        = URW_RX_IDLE;
							st_next.idle_armed = 1'b1;
							if (stby && !(wake_sel && st.shreg[8])) begin
								st_next.idle_armed = 1'b1; // standby drops the character
							end else if (st_next.stat[`URW_S_FULL]) begin
								ovr_ev = 1'b1;
								st_next.stat[`URW_S_OR] = 1'b1; // RULE_15
							end else begin
								ld_ev        = 1'b1;
								st_next.data = chr; // break leaves zero data here
								st_next.stat[`URW_S_FULL] = 1'b1; // RULE_13 RULE_08
								st_next.stat[`URW_S_FE] = st_next.stat[`URW_S_FE] | fe_v; // RULE_01 RULE_02 RULE_03 RULE_04
								st_next.stat[`URW_S_NF] = st_next.stat[`URW_S_NF] | nf_v
									| st.nf_acc; // RULE_04 RULE_16
								st_next.stat[`URW_S_PE] = st_next.stat[`URW_S_PE] | par_bad; // RULE_18
								if (stby) begin
									st_next.ctl2[`URW_C2_STBY] = 1'b0; // RULE_08 RULE_25
								end
							end
						end
					end
					default: st_next.fsm = URW_RX_IDLE;
				endcase
				// consecutive-ones counter toward an idle character
				if (!line || !cnt_en) begin
					st_next.ones = 8'h00;
				end else if (st.ones != idle_thr) begin
					st_next.ones = st.ones + 8'h01;
					idle_hit     = (st.ones + 8'h01 == idle_thr); // RULE_14
				end
				if (idle_hit && st.idle_armed && !stby) begin
					st_next.stat[`URW_S_IDLE] = 1'b1; // RULE_14
					st_next.idle_armed        = 1'b0;
				end
			end
			// idle-line wake is a level so a cleared wake select can wake at once
			if (stby && !wake_sel && st.ones == idle_thr) begin
				st_next.ctl2[`URW_C2_STBY] = 1'b0; // RULE_10 RULE_12 RULE_25
			end
		end

		// write channel: address and data taken in either order
		if (axi_i.awvalid && st.awrdy) begin
			st_next.aw_hold = 1'b1;
			st_next.awaddr  = axi_i.awaddr;
		end
		if (axi_i.wvalid && st.wrdy) begin
			st_next.w_hold = 1'b1;
			st_next.wdata  = axi_i.wdata;
			st_next.wstrb  = axi_i.wstrb;
		end
		if (wr_go) begin
			st_next.aw_hold = 1'b0;
			st_next.w_hold  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = `URW_RESP_OKAY;
			if (wait_mode_i || stop_mode_i || wsel == URW_R_NONE) begin
				st_next.bresp = `URW_RESP_SLVERR; // RULE_20
			end else begin
				// software write to standby wins over a same-cycle wake
				case (wsel)
					URW_R_CTL1: begin
						wtmp         = apply_strb({16'h0000, st.ctl1}, st.wdata, st.wstrb);
						st_next.ctl1 = wtmp[15:0];
					end
					URW_R_CTL2: begin
						wtmp         = apply_strb({29'h00000000, st_next.ctl2}, st.wdata,
							st.wstrb);
						st_next.ctl2 = wtmp[2:0]; // RULE_07 RULE_09
					end
					URW_R_CTL3: begin
						wtmp         = apply_strb({28'h0000000, st.ctl3}, st.wdata, st.wstrb);
						st_next.ctl3 = wtmp[3:0];
					end
					URW_R_BRK: begin
						wtmp        = apply_strb({31'h00000000, st.bce}, st.wdata, st.wstrb);
						st_next.bce = wtmp[0];
					end
					default:    st_next.bce = st.bce; // status and data are read-only
				endcase
			end
		end else if (st.bvalid && axi_i.bready) begin
			st_next.bvalid = 1'b0;
		end
		st_next.awrdy = !st_next.aw_hold && !st_next.bvalid;
		st_next.wrdy  = !st_next.w_hold && !st_next.bvalid;
		st_next.arrdy = !st_next.rvalid;

		// interrupt requests; standby silences the receiver request
		st_next.rx_irq = !st_next.ctl2[`URW_C2_STBY]
			&& ((st_next.stat[`URW_S_FULL] && st_next.ctl2[`URW_C2_RXIE])
			|| (st_next.stat[`URW_S_IDLE] && st_next.ctl2[`URW_C2_IDLE_IRQ_EN])); // RULE_07 RULE_13 RULE_27
		st_next.err_irq = |(st_next.stat[3:0] & st_next.ctl3); // RULE_15 RULE_16 RULE_17 RULE_18 RULE_26
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else if (clk_en_i) begin
			st <= st_next;
		end
	end

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_char_load;
		clk_en_i && ld_ev;
	endsequence
	sequence s_char_done;
		clk_en_i && done_ev;
	endsequence

	a_fe_zero_stop: assert property (s_char_load ##0 fe_v |=> st.stat[`URW_S_FE]) // RULE_01
		else $error("framing error not set on low stop sample");
	a_fe_with_full: assert property ($rose(st.stat[`URW_S_FE])
		|-> st.stat[`URW_S_FULL] && $past(ld_ok)) // RULE_02
		else $error("framing error rose without a character load");
	a_break_fe: assert property (s_char_load ##0 (st.shreg == 9'h000) ##0 (ones3 == 2'h0)
		|=> st.stat[`URW_S_FE] && st.data == 9'h000) // RULE_03
		else $error("break character did not set framing error");
	a_stop_noise: assert property (s_char_load ##0 (ones3 == 2'h2) ##0 !st.stat[`URW_S_FE]
		|=> st.stat[`URW_S_NF] && !st.stat[`URW_S_FE]) // RULE_04
		else $error("single bad stop sample mishandled");
	a_resync_rt: assert property (clk_en_i && resync_ev
		|=> st.rt == `URW_RT_EDGE_NEXT && st.fsm != URW_RX_IDLE) // RULE_05
		else $error("sample clock not realigned on edge");
	a_stop_point: assert property (s_char_done |-> st.rt == `URW_RT_S10
		&& st.fsm == URW_RX_STOP) // RULE_06
		else $error("stop sampled at wrong point");
	a_standby_mute: assert property (st.ctl2[`URW_C2_STBY] |-> !rx_irq_o) // RULE_07
		else $error("receiver request active in standby");
	a_addr_wake: assert property (s_char_load ##0 st.ctl2[`URW_C2_STBY] ##0 !wr_go
		|=> !st.ctl2[`URW_C2_STBY] && st.stat[`URW_S_FULL]) // RULE_08
		else $error("address mark did not wake receiver");
	a_overrun_keep: assert property (s_char_done ##0 ovr_ev
		|=> st.stat[`URW_S_OR] && st.data == $past(st.data)) // RULE_15
		else $error("overrun lost old data or flag");
	a_wait_block: assert property (clk_en_i && rd_hs && wait_mode_i
		|=> st.rvalid && st.rresp == `URW_RESP_SLVERR && st.rdata == 32'h00000000) // RULE_20
		else $error("register reachable during wait mode");
	a_break_hold: assert property (clk_en_i && lock
		|=> (st.stat | $past(st.stat)) == st.stat) // RULE_22
		else $error("status flag cleared in locked break");
	a_err_or: assert property (err_irq_o == |(st.stat[3:0] & st.ctl3)) // RULE_26
		else $error("error request not the gated flag or");
endmodule

// >>> urw_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ns
module urw_tx_model (
	input  wire logic clk_i,   // bench clock
	output logic      line_o   // serial line, idles high
);
	// line rests high between frames, as a pulled-up idle line does
	initial line_o = 1'b1;

	// start, eight data bits lsb first, stop; 16 clocks a bit at divisor 0
	task automatic send(input logic [7:0] d, input logic stop_b);
		logic [9:0] f;
		f = {stop_b, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			line_o <= f[i];
			repeat (15) @(posedge clk_i);
		end
		@(posedge clk_i);
		line_o <= 1'b1;
	endtask
endmodule

// >>> urw_rx_top_tb.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ns
`include "urw_defines.svh"
module urw_rx_top_tb;
	import urw_pkg::*;
	logic         clk;
	logic         rst_n;
	logic         wm;
	logic         sm;
	logic         dbg;
	logic         rx_line;
	logic         rx_irq;
	logic         err_irq;
	urw_axi_in_t  ai;
	urw_axi_out_t ao;
	int           n_mismatch;
	int           checks;

	urw_tx_model tx (.clk_i(clk), .line_o(rx_line));

	urw_rx_top uut (
		.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .rx_pin_i(rx_line),
		.wait_mode_i(wm), .stop_mode_i(sm), .debug_break_i(dbg),
		.axi_i(ai), .axi_o(ao), .rx_irq_o(rx_irq), .err_irq_o(err_irq)
	);

	// ------------------------------------------------------------
	// report helpers
	// ------------------------------------------------------------
	task automatic close_out;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// a wait that ran out of its bound ends the run
	task automatic guard(input int n, input int lim);
		if (n >= lim) begin
			n_mismatch++;
			close_out;
		end
	endtask

	// ------------------------------------------------------------
	// axi4-lite master; readiness looked at on the falling edge, so
	// the handshake edge itself is never raced
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic da, dw, ta, tw;
		int   n;
		ai.awaddr <= {24'h0, a};
		ai.wdata <= d;
		ai.wstrb <= 4'hf;
		ai.awvalid <= 1'b1;
		ai.wvalid <= 1'b1;
		ai.bready <= 1'b1;
		da = 1'b0;
		dw = 1'b0;
		n = 0;
		while (!(da && dw) && n < 40) begin
			@(negedge clk);
			n++;
			ta = !da && ao.awready === 1'b1;
			tw = !dw && ao.wready === 1'b1;
			@(posedge clk);
			if (ta) begin
				da = 1'b1;
				ai.awvalid <= 1'b0;
			end
			if (tw) begin
				dw = 1'b1;
				ai.wvalid <= 1'b0;
			end
		end
		do begin
			@(negedge clk);
			n++;
		end while (ao.bvalid !== 1'b1 && n < 80);
		guard(n, 80);
		chk("bresp", {30'h0, er}, {30'h0, ao.bresp});
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		ai.araddr <= {24'h0, a};
		ai.arvalid <= 1'b1;
		ai.rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ao.arready !== 1'b1 && n < 40);
		@(posedge clk);
		ai.arvalid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (ao.rvalid !== 1'b1 && n < 80);
		guard(n, 80);
		chk("rdata", e, ao.rdata);
		chk("rresp", {30'h0, er}, {30'h0, ao.rresp});
		@(posedge clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_good;
		tx.send(8'h5a, 1'b1);
		rd(`URW_OFF_STAT1, 32'h20, 2'h0);
		chk("rx_irq", 32'h1, {31'h0, rx_irq});
		rd(`URW_OFF_DATA, 32'h5a, 2'h0);
		repeat (200) @(posedge clk);
		rd(`URW_OFF_STAT1, 32'h10, 2'h0);
		rd(`URW_OFF_DATA, 32'h5a, 2'h0);
	endtask

	// stop bit held low: framing error beside the full flag
	task automatic s_frame;
		tx.send(8'h81, 1'b0);
		rd(`URW_OFF_STAT1, 32'h22, 2'h0);
		chk("err_irq", 32'h1, {31'h0, err_irq});
		rd(`URW_OFF_DATA, 32'h181, 2'h0);
	endtask

	// second character lands on an unread first one
	task automatic s_overrun;
		tx.send(8'h33, 1'b1);
		tx.send(8'hcc, 1'b1);
		rd(`URW_OFF_STAT1, 32'h28, 2'h0);
		chk("err_irq", 32'h0, {31'h0, err_irq});
		rd(`URW_OFF_DATA, 32'h33, 2'h0);
	endtask

	// locked debug break: the two-step clear must not act until after it
	task automatic s_break;
		tx.send(8'h21, 1'b1);
		dbg <= 1'b1;
		rd(`URW_OFF_STAT1, 32'h20, 2'h0);
		rd(`URW_OFF_DATA, 32'h21, 2'h0);
		rd(`URW_OFF_STAT1, 32'h20, 2'h0);
		dbg <= 1'b0;
		rd(`URW_OFF_STAT1, 32'h20, 2'h0);
		rd(`URW_OFF_DATA, 32'h21, 2'h0);
		rd(`URW_OFF_STAT1, 32'h0, 2'h0);
	endtask

	task automatic s_wake;
		wr(`URW_OFF_CTL1, 32'h2);
		wr(`URW_OFF_CTL2, 32'h5);
		tx.send(8'h12, 1'b1);
		rd(`URW_OFF_STAT1, 32'h0, 2'h0);
		chk("rx_irq", 32'h0, {31'h0, rx_irq});
		tx.send(8'h93, 1'b1);
		rd(`URW_OFF_STAT1, 32'h20, 2'h0);
		rd(`URW_OFF_CTL2, 32'h1, 2'h0);
		chk("rx_irq", 32'h1, {31'h0, rx_irq});
		rd(`URW_OFF_DATA, 32'h193, 2'h0);
	endtask

	// unmapped place, then accesses while the processor waits and while it is in stop mode
	task automatic s_bus;
		rd(8'h18, 32'h0, 2'h2);
		wm <= 1'b1;
		rd(`URW_OFF_CTL2, 32'h0, 2'h2);
		wr(`URW_OFF_CTL2, 32'h2, 2'h2);
		wm <= 1'b0;
		rd(`URW_OFF_CTL2, 32'h1, 2'h0);
		sm <= 1'b1;
		rd(`URW_OFF_CTL2, 32'h0, 2'h2);
		sm <= 1'b0;
		rd(`URW_OFF_CTL2, 32'h1, 2'h0);
	endtask

	// ------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		close_out;
	end

	initial begin
		rst_n = 1'b0;
		wm = 1'b0;
		sm = 1'b0;
		dbg = 1'b0;
		ai = '0;
		n_mismatch = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wr(`URW_OFF_CTL3, 32'h2);
		wr(`URW_OFF_CTL2, 32'h1);
		s_good;
		s_frame;
		s_overrun;
		s_break;
		s_wake;
		s_bus;
		close_out;
	end
endmodule
